/* common/sffa_defs.vh */
// Purpose: Constants for the synthesizer fine frequency adjust block
// Assumes: Byte-wide register port, 8-bit addresses
// Notes:   Offsets are byte register addresses
`ifndef SFFA_DEFS_VH
`define SFFA_DEFS_VH

`define SFFA_AW              8
`define SFFA_DW              8
`define SFFA_OFS_W           32
`define SFFA_ADDR_EN_A       8'hec
`define SFFA_ADDR_OFS_A0     8'hed
`define SFFA_ADDR_EN_B       8'hf1
`define SFFA_ADDR_OFS_B0     8'hf2
`define SFFA_ADDR_SPUR       8'hf7
`define SFFA_ADDR_STATUS     8'hf8
`define SFFA_EN_BIT          0
`define SFFA_RST_BYTE        8'h00
`define SFFA_RST_WORD        32'h0000_0000
`define SFFA_RECONF_MS       200
`define SFFA_CLK_HZ          20000000
`define SFFA_CNT_W           23
`define SFFA_ONE             23'h00_0001
`define SFFA_ZERO            23'h00_0000
`define SFFA_HZ_PER_KHZ      1000
`define SFFA_OFS_BYTES       8'h04
`define SFFA_LANE_TOP        2'h3

`endif

/* rtl/sffa_offset_byte.v */
// Purpose: Byte staging for one 32-bit offset register
// Assumes: Bytes written low address first, top byte last
// Notes:   Whole word commits on write of the top byte
`timescale 1ns/1ns
`default_nettype none
`include "sffa_defs.vh"

module sffa_offset_byte (
	input  wire                      i_clk,
	input  wire                      i_resetn,
	input  wire                      i_we,
	input  wire [1:0]                i_lane,
	input  wire [`SFFA_DW-1:0]       i_wdata,
	output reg  [`SFFA_OFS_W-1:0]    o_word
);

	reg [`SFFA_OFS_W-1:0] stage_r;
	reg [`SFFA_OFS_W-1:0] stage_nxt;

	always @* begin
		stage_nxt = stage_r;
		case (i_lane)
			2'h0: stage_nxt[7:0]   = i_wdata;
			2'h1: stage_nxt[15:8]  = i_wdata;
			2'h2: stage_nxt[23:16] = i_wdata;
			default: stage_nxt[31:24] = i_wdata;
		endcase
	end

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stage_r <= `SFFA_RST_WORD;
			o_word  <= `SFFA_RST_WORD;
		end else if (i_we) begin
			stage_r <= stage_nxt;
			if (i_lane == `SFFA_LANE_TOP) begin
				o_word <= stage_nxt; // RL16
			end
		end
	end

endmodule
`default_nettype wire

/* rtl/sffa_top.v */
// Purpose: Fine frequency adjust registers for two synthesizers
// Assumes: Synchronous register port, 20 MHz clock
// Notes:   Effective offsets go to the synthesis engines
//
// Rules this block and its host follow
// RL1 - Offset A is signed two's complement
// RL2 - Offset B is signed two's complement
// RL3 - One LSB moves frequency 2^-32
// RL4 - Output is finit times one plus offset
// RL5 - New offset applies live, no restart
// RL6 - Enable A zero forces offset A ignored
// RL7 - Enable B zero forces offset B ignored
// RL8 - Enable B bit0 switches, bits7:1 reserved
// RL9 - Host keeps offset A within half percent
// RL10 - Host keeps offset B within half percent
// RL11 - Spur setting change starts 200 ms reconfig
// RL12 - Host stays off bus during reconfig
// RL13 - Host writes vendor spur values, 24.576 MHz
// RL14 - Spur setting is full 8-bit register
// RL15 - Enable A bit0 switches, rest reserved
// RL16 - Reserved zero; offsets commit whole words
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "sffa_defs.vh"

module sffa_top (
	input  wire                      i_clk,
	input  wire                      i_resetn,
	input  wire [`SFFA_AW-1:0]       i_addr,
	input  wire [`SFFA_DW-1:0]       i_wdata,
	input  wire                      i_wr,
	input  wire                      i_rd,
	output reg  [`SFFA_DW-1:0]       o_rdata,
	output reg  signed [`SFFA_OFS_W-1:0] o_offset_a,
	output reg  signed [`SFFA_OFS_W-1:0] o_offset_b,
	output reg  [`SFFA_DW-1:0]       o_spur_setting,
	output reg                       o_reconfig_busy
);

	localparam [31:0] RECONF_CYC =
		(`SFFA_CLK_HZ / `SFFA_HZ_PER_KHZ) * `SFFA_RECONF_MS;
	// Full count, busy lasts exactly the reconfig span
	localparam [`SFFA_CNT_W-1:0] RECONF_LOAD = RECONF_CYC[`SFFA_CNT_W-1:0];

	reg                       en_a_r;
	reg                       en_b_r;
	reg  [`SFFA_DW-1:0]       spur_r;
	reg  [`SFFA_CNT_W-1:0]    cnt_r;
	reg  [`SFFA_CNT_W-1:0]    cnt_nxt;
	reg  [`SFFA_DW-1:0]       rdata_nxt;
	wire [`SFFA_OFS_W-1:0]    ofs_a;
	wire [`SFFA_OFS_W-1:0]    ofs_b;
	wire                      we_ofs_a;
	wire                      we_ofs_b;
	wire                      spur_change;

	// Address window test for the 4-byte offset registers
	function in_word;
		input [`SFFA_AW-1:0] addr;
		input [`SFFA_AW-1:0] base;
		reg   [`SFFA_AW-1:0] d;
		begin
			d = addr - base;
			in_word = (d < `SFFA_OFS_BYTES);
		end
	endfunction

	function [7:0] byte_of;
		input [`SFFA_OFS_W-1:0] w;
		input [1:0]             lane;
		begin
			case (lane)
				2'h0: byte_of = w[7:0];
				2'h1: byte_of = w[15:8];
				2'h2: byte_of = w[23:16];
				default: byte_of = w[31:24];
			endcase
		end
	endfunction

	wire [`SFFA_AW-1:0] lane_a = i_addr - `SFFA_ADDR_OFS_A0;
	wire [`SFFA_AW-1:0] lane_b = i_addr - `SFFA_ADDR_OFS_B0;

	assign we_ofs_a = i_wr && in_word(i_addr, `SFFA_ADDR_OFS_A0);
	assign we_ofs_b = i_wr && in_word(i_addr, `SFFA_ADDR_OFS_B0);
	assign spur_change = i_wr && (i_addr == `SFFA_ADDR_SPUR) && (i_wdata != spur_r);

	// Offset A, signed word committed as a whole
	sffa_offset_byte u_ofs_a (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_we     (we_ofs_a),
		.i_lane   (lane_a[1:0]),
		.i_wdata  (i_wdata),
		.o_word   (ofs_a)
	); // RL1

	// Offset B, signed word committed as a whole
	sffa_offset_byte u_ofs_b (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_we     (we_ofs_b),
		.i_lane   (lane_b[1:0]),
		.i_wdata  (i_wdata),
		.o_word   (ofs_b)
	); // RL2

	// Control registers
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			en_a_r <= 1'b0;
			en_b_r <= 1'b0;
			spur_r <= `SFFA_RST_BYTE;
		end else if (i_wr) begin
			if (i_addr == `SFFA_ADDR_EN_A) begin
				en_a_r <= i_wdata[`SFFA_EN_BIT]; // RL15
			end
			if (i_addr == `SFFA_ADDR_EN_B) begin
				en_b_r <= i_wdata[`SFFA_EN_BIT]; // RL8
			end
			if (i_addr == `SFFA_ADDR_SPUR) begin
				spur_r <= i_wdata; // RL14
			end
		end
	end

	// Reconfiguration timer
	always @* begin
		cnt_nxt = cnt_r;
		if (spur_change) begin
			cnt_nxt = RECONF_LOAD; // RL11
		end else if (cnt_r != `SFFA_ZERO) begin
			cnt_nxt = cnt_r - `SFFA_ONE;
		end
	end

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_r           <= `SFFA_ZERO;
			o_reconfig_busy <= 1'b0;
		end else begin
			cnt_r           <= cnt_nxt;
			o_reconfig_busy <= spur_change || (cnt_nxt != `SFFA_ZERO); // RL11
		end
	end

	// Effective offsets toward the synthesis engines
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_offset_a     <= `SFFA_RST_WORD;
			o_offset_b     <= `SFFA_RST_WORD;
			o_spur_setting <= `SFFA_RST_BYTE;
		end else begin
			o_offset_a     <= en_a_r ? ofs_a : `SFFA_RST_WORD; // RL6 RL3 RL4 RL5
			o_offset_b     <= en_b_r ? ofs_b : `SFFA_RST_WORD; // RL7 RL3 RL4 RL5
			o_spur_setting <= spur_r;
		end
	end

	// Read mux
	always @* begin
		rdata_nxt = `SFFA_RST_BYTE;
		if (i_addr == `SFFA_ADDR_EN_A) begin
			rdata_nxt = {7'h00, en_a_r}; // RL16
		end else if (i_addr == `SFFA_ADDR_EN_B) begin
			rdata_nxt = {7'h00, en_b_r}; // RL16
		end else if (in_word(i_addr, `SFFA_ADDR_OFS_A0)) begin
			rdata_nxt = byte_of(ofs_a, lane_a[1:0]);
		end else if (in_word(i_addr, `SFFA_ADDR_OFS_B0)) begin
			rdata_nxt = byte_of(ofs_b, lane_b[1:0]);
		end else if (i_addr == `SFFA_ADDR_SPUR) begin
			rdata_nxt = spur_r;
		end else if (i_addr == `SFFA_ADDR_STATUS) begin
			rdata_nxt = {7'h00, o_reconfig_busy};
		end
	end

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= `SFFA_RST_BYTE;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= `SFFA_RST_BYTE;
		end
	end

endmodule
`default_nettype wire

/* bench/sffa_top_assertions.sv */
// Purpose: Port checks for sffa_top
// Assumes: Ports of sffa_top only
// Notes:   Bind at the foot
`timescale 1ns/1ns
`default_nettype none
`include "sffa_defs.vh"
module sffa_chk (
	input wire logic               i_clk,
	input wire logic               i_resetn,
	input wire logic [7:0]         i_addr,
	input wire logic [7:0]         i_wdata,
	input wire logic               i_wr,
	input wire logic               i_rd,
	input wire logic [7:0]         o_rdata,
	input wire logic signed [31:0] o_offset_a,
	input wire logic signed [31:0] o_offset_b,
	input wire logic [7:0]         o_spur_setting,
	input wire logic               o_reconfig_busy
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property p_rsv_a; i_rd && i_addr == `SFFA_ADDR_EN_A |=> o_rdata[7:1] == 7'h00; endproperty
	a_rsv_a: assert property (p_rsv_a) else $error("enable a reserved bits");
	property p_rsv_b; i_rd && i_addr == `SFFA_ADDR_EN_B |=> o_rdata[7:1] == 7'h00; endproperty
	a_rsv_b: assert property (p_rsv_b) else $error("enable b reserved bits");
	property p_off_a; i_wr && i_addr == `SFFA_ADDR_EN_A && !i_wdata[0] |-> ##2 o_offset_a == 0;
	endproperty
	a_off_a: assert property (p_off_a) else $error("offset a not cleared");
	property p_off_b; i_wr && i_addr == `SFFA_ADDR_EN_B && !i_wdata[0] |-> ##2 o_offset_b == 0;
	endproperty
	a_off_b: assert property (p_off_b) else $error("offset b not cleared");
	property p_spur; i_wr && i_addr == `SFFA_ADDR_SPUR |-> ##2 o_spur_setting == $past(i_wdata, 2);
	endproperty
	a_spur: assert property (p_spur) else $error("spur setting wrong");
	property p_go; i_wr && i_addr == `SFFA_ADDR_SPUR && i_wdata != o_spur_setting
		&& !o_reconfig_busy |=> o_reconfig_busy; endproperty
	a_go: assert property (p_go) else $error("reconfig not started");
	property p_hold; $rose(o_reconfig_busy) |=> o_reconfig_busy [*8]; endproperty
	a_hold: assert property (p_hold) else $error("reconfig ended early");
	property p_src; !$stable(o_offset_a) |-> $past(i_wr, 2); endproperty
	a_src: assert property (p_src) else $error("offset a changed unprompted");
	c_busy: cover property ($rose(o_reconfig_busy));
	c_neg: cover property (o_offset_b < 0);
	c_pos: cover property (o_offset_a > 0);
endmodule
bind sffa_top sffa_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_offset_a(o_offset_a),
	.o_offset_b(o_offset_b), .o_spur_setting(o_spur_setting), .o_reconfig_busy(o_reconfig_busy));
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for sffa_top
// Assumes: 20 MHz clock
// Notes:   Reconfig checked to start, hold, clear on reset and not start on an unchanged value
`timescale 1ns/1ns
`default_nettype none
`include "sffa_defs.vh"
module testbench;
	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	wire  [7:0]  o_rdata;
	wire  [31:0] o_offset_a;
	wire  [31:0] o_offset_b;
	wire  [7:0]  o_spur_setting;
	wire         o_reconfig_busy;
	int          n_fail = 0;
	int          n_compared = 0;
	sffa_top DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_offset_a(o_offset_a),
		.o_offset_b(o_offset_b), .o_spur_setting(o_spur_setting),
		.o_reconfig_busy(o_reconfig_busy));
	initial forever #25 i_clk = ~i_clk;
	task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
	endtask
	task nop(input int n);
		repeat (n) begin
			@(posedge i_clk);
			i_wr <= 1'b0;
			i_rd <= 1'b0;
		end
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= a;
		nop(1);
		ck("read data", {24'h0, e}, {24'h0, o_rdata});
	endtask
	task t_reset;
		ck("offset a", 32'h0, o_offset_a);
		ck("offset b", 32'h0, o_offset_b);
		rd(`SFFA_ADDR_EN_B, 8'h00);
		rd(`SFFA_ADDR_EN_A, 8'h00);
		rd(`SFFA_ADDR_SPUR, 8'h00);
		rd(`SFFA_ADDR_STATUS, 8'h00);
		rd(8'h10, 8'h00);
		$display("test reset done");
	endtask
	task t_ofs(input logic [7:0] en, input logic [7:0] b0, input logic [31:0] v, input logic sb);
		wr(en, 8'hff);
		rd(en, 8'h01);
		for (int i = 0; i < 3; i++) wr(b0 + 8'(i), v[8*i +: 8]);
		nop(2);
		ck("staged", 32'h0, sb ? o_offset_b : o_offset_a);
		wr(b0 + 8'h03, v[31:24]);
		nop(2);
		ck("live", v, sb ? o_offset_b : o_offset_a);
		rd(b0, v[7:0]);
		wr(en, 8'hfe);
		nop(2);
		ck("disabled", 32'h0, sb ? o_offset_b : o_offset_a);
		wr(en, 8'h01);
		nop(2);
		ck("enabled", v, sb ? o_offset_b : o_offset_a);
		$display("test offset done");
	endtask
	task t_spur;
		wr(`SFFA_ADDR_SPUR, 8'h5a);
		nop(2);
		ck("busy", 32'h1, {31'h0, o_reconfig_busy});
		ck("spur", 32'h5a, {24'h0, o_spur_setting});
		nop(1000);
		ck("busy held", 32'h1, {31'h0, o_reconfig_busy});
		@(posedge i_clk);
		i_resetn <= 1'b0;
		nop(2);
		ck("busy reset", 32'h0, {31'h0, o_reconfig_busy});
		@(posedge i_clk);
		i_resetn <= 1'b1;
		nop(1);
		ck("offset a reset", 32'h0, o_offset_a);
		ck("offset b reset", 32'h0, o_offset_b);
		ck("spur reset", 32'h0, {24'h0, o_spur_setting});
		rd(`SFFA_ADDR_EN_A, 8'h00);
		wr(`SFFA_ADDR_SPUR, 8'h00);
		nop(2);
		ck("no reconfig", 32'h0, {31'h0, o_reconfig_busy});
		rd(`SFFA_ADDR_STATUS, 8'h00);
		$display("test spur done");
	endtask
	task final_report;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		nop(5);
		i_resetn <= 1'b1;
		t_reset;
		t_ofs(`SFFA_ADDR_EN_B, `SFFA_ADDR_OFS_B0, 32'hffff_ff00, 1'b1);
		t_ofs(`SFFA_ADDR_EN_A, `SFFA_ADDR_OFS_A0, 32'h0012_3456, 1'b0);
		t_spur;
		final_report;
	end
	initial begin
		#1000000;
		n_fail++;
		final_report;
	end
endmodule
`default_nettype wire
